//--- hdl/gyro_accel_consts.svh
`ifndef GYRO_ACCEL_CONSTS_SVH
`define GYRO_ACCEL_CONSTS_SVH

`define OD_IDX_FILT_EN     16'h2002
`define OD_IDX_CUTOFF      16'h2003
`define OD_IDX_ACCEL_DATA  16'h4000
`define OD_IDX_ACCEL_LAT   16'h4010
`define OD_IDX_ACCEL_TRUST 16'h4020
`define OD_IDX_ACCEL_TEMP  16'h4070
`define OD_IDX_RATE_DATA   16'h4100
`define OD_IDX_RATE_LAT    16'h4110
`define OD_IDX_RATE_TRUST  16'h4120
`define OD_IDX_GYRO_TEMP   16'h4150

`define SUB_COUNT          8'h00
`define SUB_LAST3          8'h03
`define SUB_LAST1          8'h01
`define COUNT3             32'h0000_0003
`define COUNT1             32'h0000_0001

`define FILT_EN_RESET      8'h01
`define FILT_EN_MAX        32'h0000_0001
`define CUTOFF_RESET       8'h05
`define CUTOFF_MIN         8'h01
`define CUTOFF_MAX         8'h23
`define CUTOFF_FAST        8'h1C
`define SHIFT_MIN          4'h1
`define SHIFT_MAX          4'h8
`define FRAC_ZERO          8'h00

`define TRUST_OK           8'h00
`define TRUST_SUSPECT      8'h01
`define TRUST_ERROR        8'h02
`define TEMP_LOW           16'hFFD8
`define TEMP_HIGH          16'h007D

`define STRAP_SETTLE       2'h2

`endif

//--- hdl/gyro_accel_pkg.sv
`default_nettype none
package gyro_accel_pkg;

    typedef enum logic [1:0] {
        ABORT_NONE,
        ABORT_NO_ENTRY,
        ABORT_READ_ONLY,
        ABORT_RANGE
    } od_abort_t;

    typedef struct packed {
        logic [23:0] acc;
        logic [15:0] filt;
        logic        filt_valid;
    } lowpass_state_t;

    typedef struct packed {
        logic            strap_meta;
        logic            strap_sync;
        logic [1:0]      strap_cnt;
        logic            strap_done;
        logic            single_axis;
        logic [7:0]      filt_en;
        logic [7:0]      cutoff;
        logic [2:0][15:0] rate;
        logic [2:0][15:0] gtemp;
        logic [15:0]     rate_lat;
        logic [7:0]      rate_trust;
        logic [2:0][15:0] accel;
        logic [15:0]     atemp;
        logic [15:0]     accel_lat;
        logic [7:0]      accel_trust;
        logic            ack;
        logic            abort;
        od_abort_t       abort_code;
        logic [31:0]     rdata;
    } readout_state_t;

endpackage
`default_nettype wire

//--- hdl/gyro_lowpass.sv
`timescale 1ns/1ps
`default_nettype none
`include "gyro_accel_consts.svh"
module gyro_lowpass
    import gyro_accel_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        sample_valid,
    input  wire logic        enable,
    input  wire logic [3:0]  shift,
    input  wire logic [15:0] sample_in,
    output logic      [15:0] filt_out,
    output logic             filt_valid
);
    lowpass_state_t state_reg;
    lowpass_state_t state_next;

    always_comb begin
        logic [24:0] diff;
        logic [24:0] step;
        diff = 25'h0;
        step = 25'h0;
        state_next = state_reg;
        state_next.filt_valid = sample_valid;
        if (sample_valid) begin
            diff = {sample_in[15], sample_in, `FRAC_ZERO} - {state_reg.acc[23], state_reg.acc};
            step = 25'($signed(diff) >>> shift);
            if (enable) begin
                state_next.acc = state_reg.acc + step[23:0];
            end else begin
                // Bypass keeps the accumulator on the input so enabling causes no step
                state_next.acc = {sample_in, `FRAC_ZERO};
            end
            state_next.filt = state_next.acc[23:8];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign filt_out   = state_reg.filt;
    assign filt_valid = state_reg.filt_valid;

    a_bypass_passes: assert property (@(posedge core_clk) disable iff (rst)
        sample_valid && !enable |=> filt_valid && filt_out == $past(sample_in))
        else $error("bypassed filter did not pass the sample");

endmodule
`default_nettype wire

//--- hdl/gyro_accel_readout.sv
`timescale 1ns/1ps
`default_nettype none
`include "gyro_accel_consts.svh"
module gyro_accel_readout
    import gyro_accel_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        single_axis_strap,
    input  wire logic        gyro_sample_valid,
    input  wire logic [15:0] gyro_rate_in_x,
    input  wire logic [15:0] gyro_rate_in_y,
    input  wire logic [15:0] gyro_rate_in_z,
    input  wire logic [15:0] gyro_temp_in_x,
    input  wire logic [15:0] gyro_temp_in_y,
    input  wire logic [15:0] gyro_temp_in_z,
    input  wire logic        gyro_fault,
    input  wire logic [15:0] rate_latency_in,
    input  wire logic        accel_sample_valid,
    input  wire logic [15:0] accel_in_x,
    input  wire logic [15:0] accel_in_y,
    input  wire logic [15:0] accel_in_z,
    input  wire logic [15:0] accel_temp_in,
    input  wire logic        accel_fault,
    input  wire logic [15:0] accel_latency_in,
    input  wire logic        od_req,
    input  wire logic        od_write,
    input  wire logic [15:0] od_index,
    input  wire logic [7:0]  od_subindex,
    input  wire logic [31:0] od_wdata,
    output logic             od_ack,
    output logic             od_abort,
    output od_abort_t        od_abort_code,
    output logic      [31:0] od_rdata,
    output logic      [15:0] rate_x,
    output logic      [15:0] rate_y,
    output logic      [15:0] rate_z,
    output logic      [15:0] rate_latency,
    output logic      [7:0]  rate_trust,
    output logic      [15:0] gyro_temp_x,
    output logic      [15:0] gyro_temp_y,
    output logic      [15:0] gyro_temp_z,
    output logic      [15:0] accel_x,
    output logic      [15:0] accel_y,
    output logic      [15:0] accel_z,
    output logic      [15:0] accel_latency,
    output logic      [7:0]  accel_trust,
    output logic      [15:0] accel_temp
);
    localparam readout_state_t ST_RESET = '{
        filt_en:    `FILT_EN_RESET,
        cutoff:     `CUTOFF_RESET,
        abort_code: ABORT_NONE,
        default:    '0
    };

    readout_state_t   state_reg;
    readout_state_t   state_next;
    logic [2:0][15:0] rate_in;
    logic [2:0][15:0] filt_out;
    logic [2:0]       filt_valid;
    logic [3:0]       filt_shift;

    function automatic logic temp_bad(input logic [15:0] t);
        return ($signed(t) < $signed(`TEMP_LOW)) || ($signed(t) > $signed(`TEMP_HIGH));
    endfunction

    // Error outranks an out-of-range temperature
    function automatic logic [7:0] trust_of(
        input logic        fault,
        input logic [15:0] ta,
        input logic [15:0] tb,
        input logic [15:0] tc
    );
        if (fault) begin
            return `TRUST_ERROR;
        end
        if (temp_bad(ta) || temp_bad(tb) || temp_bad(tc)) begin
            return `TRUST_SUSPECT;
        end
        return `TRUST_OK;
    endfunction

    function automatic logic [31:0] sext(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction

    // Sub 0 gives the count, subs 1..3 the signed axis values
    function automatic logic [31:0] entry3(
        input logic [2:0][15:0] v,
        input logic [7:0]       sub
    );
        case (sub)
            `SUB_COUNT: return `COUNT3;
            8'h01:      return sext(v[0]);
            8'h02:      return sext(v[1]);
            8'h03:      return sext(v[2]);
            default:    return 32'h0000_0000;
        endcase
    endfunction

    // Higher cut-off means a smaller shift and a faster filter
    function automatic logic [3:0] cutoff_shift(input logic [7:0] c);
        if (c >= `CUTOFF_FAST) begin
            return `SHIFT_MIN;
        end
        return `SHIFT_MAX - {1'b0, c[4:2]};
    endfunction

    assign rate_in    = {gyro_rate_in_z, gyro_rate_in_y, gyro_rate_in_x};
    assign filt_shift = cutoff_shift(state_reg.cutoff);

    genvar ax;
    generate
        for (ax = 0; ax < 3; ax++) begin : g_axis
            gyro_lowpass u_lowpass (
                .core_clk     (core_clk),
                .rst          (rst),
                .sample_valid (gyro_sample_valid),
                .enable       (state_reg.filt_en[0]),
                .shift        (filt_shift),
                .sample_in    (rate_in[ax]),
                .filt_out     (filt_out[ax]),
                .filt_valid   (filt_valid[ax])
            );
        end
    endgenerate

    always_comb begin
        logic        hit;
        logic        ro;
        logic [31:0] rv;
        logic [15:0] tx;
        logic [15:0] ty;
        hit = 1'b1;
        ro  = 1'b1;
        rv  = 32'h0000_0000;
        tx  = gyro_temp_in_x;
        ty  = gyro_temp_in_y;
        state_next = state_reg;

        // Strap is a pin: synchronised, then caught once after it settles
        state_next.strap_meta = single_axis_strap;
        state_next.strap_sync = state_reg.strap_meta;
        if (state_reg.strap_cnt != `STRAP_SETTLE) begin
            state_next.strap_cnt = state_reg.strap_cnt + 2'h1;
        end else if (!state_reg.strap_done) begin
            state_next.single_axis = state_reg.strap_sync;
            state_next.strap_done  = 1'b1;
        end

        if (gyro_sample_valid) begin
            if (state_reg.single_axis) begin
                tx = gyro_temp_in_z;
                ty = gyro_temp_in_z;
            end
            state_next.gtemp    = {gyro_temp_in_z, ty, tx};
            state_next.rate_lat = rate_latency_in;
            state_next.rate_trust = trust_of(gyro_fault, tx, ty, gyro_temp_in_z);
        end
        if (filt_valid[0]) begin
            state_next.rate[0] = filt_out[0];
        end
        if (filt_valid[1]) begin
            state_next.rate[1] = state_reg.single_axis ? 16'h0000 : filt_out[1];
        end
        if (filt_valid[2]) begin
            state_next.rate[2] = state_reg.single_axis ? 16'h0000 : filt_out[2];
        end

        if (accel_sample_valid) begin
            state_next.accel     = {accel_in_z, accel_in_y, accel_in_x};
            state_next.atemp     = accel_temp_in;
            state_next.accel_lat = accel_latency_in;
            state_next.accel_trust = trust_of(accel_fault, accel_temp_in, accel_temp_in,
                                              accel_temp_in);
        end

        case (od_index)
            `OD_IDX_FILT_EN: begin
                ro  = 1'b0;
                hit = (od_subindex == `SUB_COUNT);
                rv  = {24'h00_0000, state_reg.filt_en};
            end
            `OD_IDX_CUTOFF: begin
                ro  = 1'b0;
                hit = (od_subindex == `SUB_COUNT);
                rv  = {24'h00_0000, state_reg.cutoff};
            end
            `OD_IDX_RATE_DATA: begin
                hit = (od_subindex <= `SUB_LAST3);
                rv  = entry3(state_reg.rate, od_subindex);
            end
            `OD_IDX_RATE_LAT: begin
                hit = (od_subindex == `SUB_COUNT);
                rv  = {16'h0000, state_reg.rate_lat};
            end
            `OD_IDX_RATE_TRUST: begin
                hit = (od_subindex == `SUB_COUNT);
                rv  = {24'h00_0000, state_reg.rate_trust};
            end
            `OD_IDX_ACCEL_TRUST: begin
                hit = (od_subindex == `SUB_COUNT);
                rv  = {24'h00_0000, state_reg.accel_trust};
            end
            `OD_IDX_GYRO_TEMP: begin
                hit = (od_subindex <= `SUB_LAST3);
                rv  = entry3(state_reg.gtemp, od_subindex);
            end
            `OD_IDX_ACCEL_DATA: begin
                hit = (od_subindex <= `SUB_LAST3);
                rv  = entry3(state_reg.accel, od_subindex);
            end
            `OD_IDX_ACCEL_LAT: begin
                hit = (od_subindex == `SUB_COUNT);
                rv  = {16'h0000, state_reg.accel_lat};
            end
            `OD_IDX_ACCEL_TEMP: begin
                hit = (od_subindex <= `SUB_LAST1);
                rv  = (od_subindex == `SUB_COUNT) ? `COUNT1 : sext(state_reg.atemp);
            end
            default: begin
                hit = 1'b0;
            end
        endcase

        state_next.ack        = od_req;
        state_next.abort      = 1'b0;
        state_next.abort_code = ABORT_NONE;
        if (od_req) begin
            state_next.rdata = 32'h0000_0000;
            if (!hit) begin
                state_next.abort      = 1'b1;
                state_next.abort_code = ABORT_NO_ENTRY;
            end else if (!od_write) begin
                state_next.rdata = rv;
            end else if (ro) begin
                state_next.abort      = 1'b1;
                state_next.abort_code = ABORT_READ_ONLY;
            end else if (od_index == `OD_IDX_FILT_EN) begin
                // enable write, 0 or 1 only
                if (od_wdata > `FILT_EN_MAX) begin
                    state_next.abort      = 1'b1;
                    state_next.abort_code = ABORT_RANGE;
                end else begin
                    state_next.filt_en = od_wdata[7:0];
                end
            end else if (od_wdata < {24'h00_0000, `CUTOFF_MIN} ||
                         od_wdata > {24'h00_0000, `CUTOFF_MAX}) begin
                state_next.abort      = 1'b1;
                state_next.abort_code = ABORT_RANGE;
            end else begin
                state_next.cutoff = od_wdata[7:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign od_ack        = state_reg.ack;
    assign od_abort      = state_reg.abort;
    assign od_abort_code = state_reg.abort_code;
    assign od_rdata      = state_reg.rdata;
    assign rate_x        = state_reg.rate[0];
    assign rate_y        = state_reg.rate[1];
    assign rate_z        = state_reg.rate[2];
    assign rate_latency  = state_reg.rate_lat;
    assign rate_trust    = state_reg.rate_trust;
    assign gyro_temp_x   = state_reg.gtemp[0];
    assign gyro_temp_y   = state_reg.gtemp[1];
    assign gyro_temp_z   = state_reg.gtemp[2];
    assign accel_x       = state_reg.accel[0];
    assign accel_y       = state_reg.accel[1];
    assign accel_z       = state_reg.accel[2];
    assign accel_latency = state_reg.accel_lat;
    assign accel_trust   = state_reg.accel_trust;
    assign accel_temp    = state_reg.atemp;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_gyro_trust_error: assert property (
        gyro_sample_valid && gyro_fault |=> rate_trust == `TRUST_ERROR)
        else $error("gyro fault not reported as trust 2");

    a_gyro_trust_cold: assert property (
        gyro_sample_valid && !gyro_fault && $signed(gyro_temp_in_z) < $signed(`TEMP_LOW)
        |=> rate_trust == `TRUST_SUSPECT)
        else $error("cold gyro not reported as trust 1");

    a_accel_trust_ok: assert property (
        accel_sample_valid && !accel_fault && !temp_bad(accel_temp_in)
        |=> accel_trust == `TRUST_OK)
        else $error("healthy accel not reported as trust 0");

    a_accel_trust_error: assert property (
        accel_sample_valid && accel_fault |=> accel_trust == `TRUST_ERROR)
        else $error("accel fault not reported as trust 2");

    a_enable_write_lands: assert property (
        od_req && od_write && od_index == `OD_IDX_FILT_EN && od_subindex == `SUB_COUNT &&
        od_wdata <= `FILT_EN_MAX |=> od_ack && !od_abort && rdata_enable_is($past(od_wdata)))
        else $error("filter enable write not stored");

    a_cutoff_in_range: assert property (
        state_reg.cutoff >= `CUTOFF_MIN && state_reg.cutoff <= `CUTOFF_MAX)
        else $error("cut-off left its range");

    a_single_temp_copy: assert property (
        state_reg.single_axis && gyro_sample_valid |=> gyro_temp_x == gyro_temp_z &&
        gyro_temp_y == gyro_temp_z)
        else $error("single-axis X/Y temperature differs from Z");

    a_rate_lat_read: assert property (
        od_req && !od_write && od_index == `OD_IDX_RATE_LAT && od_subindex == `SUB_COUNT
        |=> od_ack && !od_abort && od_rdata == {16'h0000, $past(rate_latency)})
        else $error("rate latency read returned wrong data");

    a_ro_write_abort: assert property (
        od_req && od_write && od_index == `OD_IDX_ACCEL_LAT && od_subindex == `SUB_COUNT
        |=> od_ack && od_abort && od_abort_code == ABORT_READ_ONLY)
        else $error("write to read-only latency not refused");

    a_temp_count_read: assert property (
        od_req && !od_write && od_index == `OD_IDX_GYRO_TEMP && od_subindex == `SUB_COUNT
        |=> od_rdata == `COUNT3 && !od_abort)
        else $error("gyro temperature count is not 3");

    function automatic logic rdata_enable_is(input logic [31:0] w);
        return state_reg.filt_en == w[7:0];
    endfunction

    c_gyro_suspect: cover property (rate_trust == `TRUST_SUSPECT);
    c_accel_error:  cover property (accel_trust == `TRUST_ERROR);
    c_filter_off:   cover property (state_reg.filt_en == 8'h00 && filt_valid[0]);
    c_single_axis:  cover property (state_reg.single_axis && gyro_sample_valid);

endmodule
`default_nettype wire

//--- testbench/od_master.sv
`timescale 1ns/1ps
`default_nettype none
module od_master (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic        wr,
    input  wire logic [15:0] idx,
    input  wire logic [7:0]  sub,
    input  wire logic [31:0] wdata,
    output logic             done,
    output logic             ab,
    output logic      [1:0]  code,
    output logic      [31:0] rd,
    output logic             od_req,
    output logic             od_write,
    output logic      [15:0] od_index,
    output logic      [7:0]  od_subindex,
    output logic      [31:0] od_wdata,
    input  wire logic        od_ack,
    input  wire logic        od_abort,
    input  wire logic [1:0]  od_abort_code,
    input  wire logic [31:0] od_rdata
);
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {od_req, od_write, od_index, od_subindex, od_wdata} <= '0;
            {done, ab, code, rd} <= '0;
        end else if (start) begin
            od_req      <= 1'b1;
            od_write    <= wr;
            od_index    <= idx;
            od_subindex <= sub;
            od_wdata    <= wdata;
            done        <= 1'b0;
        end else begin
            // Released fields toggle so a stale request value is never mistaken for a live one
            od_req      <= 1'b0;
            od_write    <= ~od_write;
            od_index    <= ~od_index;
            od_subindex <= ~od_subindex;
            od_wdata    <= ~od_wdata;
            if (od_ack) begin
                {ab, code, rd} <= {od_abort, od_abort_code, od_rdata};
                done           <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/gyro_accel_readout_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin errors++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module gyro_accel_readout_test
    import gyro_accel_pkg::*;
;
    logic        core_clk, rst, strap, start, wr, done, ab, gv, gf, av, af;
    logic [15:0] idx, gx, gy, gz, tx, ty, tz, glat, ax, ay, az, at, alat;
    logic [7:0]  sub;
    logic [31:0] wdata, rd;
    logic [1:0]  code;
    logic        od_req, od_write, od_ack, od_abort;
    logic [15:0] od_index;
    logic [7:0]  od_subindex;
    logic [31:0] od_wdata, od_rdata;
    od_abort_t   od_abort_code;
    logic [15:0] rate_x, rate_y, rate_z, rate_latency, gyro_temp_x, gyro_temp_y, gyro_temp_z;
    logic [15:0] accel_x, accel_y, accel_z, accel_latency, accel_temp;
    logic [7:0]  rate_trust, accel_trust;
    int          errors, samples_checked, cycles;
    logic [15:0] ttemp [6] = '{16'hFFD8, 16'hFFD7, 16'h007D, 16'h007E, 16'h0019, 16'hFFD0};
    logic        tflt  [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [7:0]  texp  [6] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h02};

    gyro_accel_readout uut (.core_clk(core_clk), .rst(rst), .single_axis_strap(strap),
        .gyro_sample_valid(gv), .gyro_rate_in_x(gx), .gyro_rate_in_y(gy), .gyro_rate_in_z(gz),
        .gyro_temp_in_x(tx), .gyro_temp_in_y(ty), .gyro_temp_in_z(tz), .gyro_fault(gf),
        .rate_latency_in(glat), .accel_sample_valid(av), .accel_in_x(ax), .accel_in_y(ay),
        .accel_in_z(az), .accel_temp_in(at), .accel_fault(af), .accel_latency_in(alat),
        .od_req(od_req), .od_write(od_write), .od_index(od_index), .od_subindex(od_subindex),
        .od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort),
        .od_abort_code(od_abort_code), .od_rdata(od_rdata), .rate_x(rate_x), .rate_y(rate_y),
        .rate_z(rate_z), .rate_latency(rate_latency), .rate_trust(rate_trust),
        .gyro_temp_x(gyro_temp_x), .gyro_temp_y(gyro_temp_y), .gyro_temp_z(gyro_temp_z),
        .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z), .accel_latency(accel_latency),
        .accel_trust(accel_trust), .accel_temp(accel_temp));

    od_master master (.core_clk(core_clk), .rst(rst), .start(start), .wr(wr), .idx(idx),
        .sub(sub), .wdata(wdata), .done(done), .ab(ab), .code(code), .rd(rd),
        .od_req(od_req), .od_write(od_write), .od_index(od_index), .od_subindex(od_subindex),
        .od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort),
        .od_abort_code(od_abort_code), .od_rdata(od_rdata));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        // Whole run needs about two hundred cycles; far above that means a hang
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s,
                        input logic [31:0] d, input od_abort_t ec, input logic [31:0] er);
        int n;
        n = 0;
        {start, wr, idx, sub, wdata} = {1'b1, w, i, s, d};
        @(posedge core_clk);
        #1;
        start = 1'b0;
        while (done !== 1'b1 && n < 10) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK("ack_seen", 1'b1, done)
        `CHK("abort_code", ec, code)
        `CHK("abort_flag", ec != ABORT_NONE, ab)
        `CHK("read_data", er, rd)
    endtask

    task automatic pulse(ref logic v);
        v = 1'b1;
        @(posedge core_clk);
        #1;
        v = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic reset_dut(input logic s);
        rst   = 1'b1;
        strap = s;
        repeat (16) @(posedge core_clk);
        #1;
        rst = 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
    endtask

    initial begin
        {strap, start, wr, idx, sub, wdata, gv, gf, av, af} = '0;
        {gx, gy, gz, tx, ty, tz, glat, ax, ay, az, at, alat} = '0;
        errors = 0;
        samples_checked = 0;
        cycles = 0;
        reset_dut(1'b0);
        xfer(0, 16'h2002, 8'h00, 0, ABORT_NONE, 32'h1);
        xfer(0, 16'h2003, 8'h00, 0, ABORT_NONE, 32'h5);
        xfer(0, 16'h4110, 8'h00, 0, ABORT_NONE, 32'h0);
        xfer(0, 16'h4010, 8'h00, 0, ABORT_NONE, 32'h0);
        xfer(0, 16'h4120, 8'h00, 0, ABORT_NONE, 32'h0);
        xfer(0, 16'h4070, 8'h01, 0, ABORT_NONE, 32'h0);
        xfer(0, 16'h4100, 8'h00, 0, ABORT_NONE, 32'h3);
        xfer(0, 16'h4150, 8'h00, 0, ABORT_NONE, 32'h3);
        xfer(0, 16'h4000, 8'h00, 0, ABORT_NONE, 32'h3);
        $display("test defaults done");
        xfer(1, 16'h4110, 8'h00, 1, ABORT_READ_ONLY, 0);
        xfer(1, 16'h4020, 8'h00, 1, ABORT_READ_ONLY, 0);
        xfer(1, 16'h2002, 8'h00, 2, ABORT_RANGE, 0);
        xfer(1, 16'h2003, 8'h00, 0, ABORT_RANGE, 0);
        xfer(1, 16'h2003, 8'h00, 36, ABORT_RANGE, 0);
        xfer(0, 16'h2003, 8'h00, 0, ABORT_NONE, 32'h5);
        xfer(0, 16'h4100, 8'h04, 0, ABORT_NO_ENTRY, 0);
        xfer(0, 16'h4130, 8'h00, 0, ABORT_NO_ENTRY, 0);
        $display("test refusals done");
        xfer(1, 16'h2002, 8'h00, 0, ABORT_NONE, 0);
        {gx, gy, gz, tx, ty, tz, glat} = {16'hFF38, 16'h0064, 16'h7FFF, 16'h0019, 16'hFFEC,
                                          16'h0030, 16'h0007};
        pulse(gv);
        `CHK("rate_x", 16'hFF38, rate_x)
        `CHK("rate_z", 16'h7FFF, rate_z)
        `CHK("gyro_temp_y", 16'hFFEC, gyro_temp_y)
        `CHK("rate_y", 16'h0064, rate_y)
        `CHK("gyro_temp_z", 16'h0030, gyro_temp_z)
        `CHK("rate_latency", 16'h0007, rate_latency)
        xfer(0, 16'h4100, 8'h01, 0, ABORT_NONE, 32'hFFFFFF38);
        xfer(0, 16'h4100, 8'h02, 0, ABORT_NONE, 32'h00000064);
        xfer(0, 16'h4150, 8'h02, 0, ABORT_NONE, 32'hFFFFFFEC);
        xfer(0, 16'h4110, 8'h00, 0, ABORT_NONE, 32'h7);
        {ax, ay, az, alat} = {16'h8001, 16'h0010, 16'hFFFF, 16'h0009};
        for (int k = 0; k < 6; k++) begin
            {tz, gf, at, af} = {ttemp[k], tflt[k], ttemp[k], tflt[k]};
            pulse(gv);
            pulse(av);
            `CHK("rate_trust", texp[k], rate_trust)
            `CHK("accel_trust", texp[k], accel_trust)
            xfer(0, 16'h4120, 8'h00, 0, ABORT_NONE, {24'h0, texp[k]});
            xfer(0, 16'h4020, 8'h00, 0, ABORT_NONE, {24'h0, texp[k]});
        end
        `CHK("accel_y", 16'h0010, accel_y)
        `CHK("accel_x", 16'h8001, accel_x)
        `CHK("accel_z", 16'hFFFF, accel_z)
        `CHK("accel_latency", 16'h0009, accel_latency)
        `CHK("accel_temp", 16'hFFD0, accel_temp)
        xfer(0, 16'h4000, 8'h01, 0, ABORT_NONE, 32'hFFFF8001);
        xfer(0, 16'h4070, 8'h01, 0, ABORT_NONE, 32'hFFFFFFD0);
        xfer(0, 16'h4010, 8'h00, 0, ABORT_NONE, 32'h9);
        $display("test sensor data done");
        xfer(1, 16'h2003, 8'h00, 35, ABORT_NONE, 0);
        gx = 16'h0000;
        pulse(gv);
        xfer(1, 16'h2002, 8'h00, 1, ABORT_NONE, 0);
        gx = 16'h0100;
        pulse(gv);
        // Cut-off 35 gives shift 1, so the first step from rest lands half way
        `CHK("rate_x", 16'h0080, rate_x)
        $display("test filter done");
        reset_dut(1'b1);
        {gx, gy, gz, tx, ty, tz, gf} = {16'h0011, 16'h0022, 16'h0033, 16'h0001, 16'h0002,
                                        16'h007E, 1'b0};
        pulse(gv);
        `CHK("rate_y", 16'h0000, rate_y)
        `CHK("rate_z", 16'h0000, rate_z)
        `CHK("gyro_temp_x", 16'h007E, gyro_temp_x)
        `CHK("rate_trust", 8'h01, rate_trust)
        xfer(0, 16'h4150, 8'h02, 0, ABORT_NONE, 32'h7E);
        $display("test single axis done");
        give_verdict();
    end
endmodule
`default_nettype wire
